// [tcc_pkg.sv]
// Shared constants and carrier types of the 8-bit timer compare unit
// Assumes a 32-bit APB register bus and pclk as the only clock
package tcc_pkg;
   // ************************************************
   // Counter range
   // ************************************************
   localparam int         TCC_W      = 8;
   localparam logic [7:0] TCC_BOTTOM = 8'h00;
   localparam logic [7:0] TCC_MAX    = 8'hff;
   localparam logic [7:0] TCC_ONE    = 8'h01;

   // ************************************************
   // Register byte offsets
   // ************************************************
   localparam logic [11:0] TCC_OFF_CONTROL = 12'h000;
   localparam logic [11:0] TCC_OFF_COUNTER = 12'h004;
   localparam logic [11:0] TCC_OFF_COMPARE = 12'h008;
   localparam logic [11:0] TCC_OFF_FLAG    = 12'h00c;
   localparam logic [11:0] TCC_OFF_MASK    = 12'h010;

   // ************************************************
   // Field positions and reset values
   // ************************************************
   localparam int         TCC_CTRL_W   = 7;
   localparam int         TCC_OVF_BIT  = 0;
   localparam int         TCC_CMP_BIT  = 1;
   localparam logic [6:0] TCC_CTRL_RST = 7'h00;
   localparam logic [1:0] TCC_MASK_RST = 2'h0;

   // ************************************************
   // Clock select, waveform and output mode codes
   // ************************************************
   localparam logic [2:0] TCC_CS_STOP    = 3'h0;
   localparam logic [2:0] TCC_CS_SYS     = 3'h1;
   localparam logic [2:0] TCC_CS_TAP0    = 3'h2;
   localparam logic [2:0] TCC_CS_FALL    = 3'h6;
   localparam logic [2:0] TCC_CS_RISE    = 3'h7;
   localparam logic [1:0] TCC_WGM_NORMAL = 2'h0;
   localparam logic [1:0] TCC_WGM_PHASE  = 2'h1;
   localparam logic [1:0] TCC_WGM_CTC    = 2'h2;
   localparam logic [1:0] TCC_WGM_FAST   = 2'h3;
   localparam logic [1:0] TCC_COM_OFF    = 2'h0;
   localparam logic [1:0] TCC_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TCC_COM_CLEAR  = 2'h2;
   localparam logic [1:0] TCC_COM_SET    = 2'h3;

   // Timer control register layout
   typedef struct packed {
      logic [1:0] compare_output_mode_field;
      logic [1:0] waveform_mode_field;
      logic [2:0] clock_select_field;
   } tcc_ctrl_type;

   // Counter events handed to the waveform generator
   typedef struct packed {
      logic tick;
      logic match;
      logic at_max;
      logic at_bottom;
      logic down;
   } tcc_evt_type;
endpackage

// [tcc_tick_sel.sv]
// Timer tick selection: stop, system clock, prescaler taps, external pin
// Assumes prescaler taps are one-cycle pulses on pclk; the pin is async
`timescale 1ns/100ps
module tcc_tick_sel
   import tcc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] clock_select_field,
   input  wire logic [3:0] prescale_tap,
   input  wire logic       external_count_pin,
   output logic            timer_tick
);
   typedef struct packed {
      logic [2:0] sync;
      logic       level;
      logic       tick;
   } tcc_sel_state_type;

   tcc_sel_state_type st_r;
   tcc_sel_state_type st_nxt;
   logic [1:0]        tap_idx;

   // Tap index for the four prescaler selections
   assign tap_idx = 2'(clock_select_field - TCC_CS_TAP0);

   // Pin synchroniser, edge detector and source mux
   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.sync = {st_r.sync[1:0], external_count_pin};
      if (st_r.sync[1] == st_r.sync[2])
      begin
         st_nxt.level = st_r.sync[2];
      end
      case (clock_select_field)
         TCC_CS_STOP: st_nxt.tick = 1'b0;
         TCC_CS_SYS:  st_nxt.tick = 1'b1;
         TCC_CS_FALL: st_nxt.tick = st_r.level & ~st_nxt.level;
         TCC_CS_RISE: st_nxt.tick = ~st_r.level & st_nxt.level;
         default:     st_nxt.tick = prescale_tap[tap_idx];
      endcase
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign timer_tick = st_r.tick;
endmodule

// [tcc_wavegen.sv]
// Waveform generator of the compare output
// Assumes events arrive unqualified alongside the timer tick that gates them here, all on pclk
`timescale 1ns/100ps
module tcc_wavegen
   import tcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [1:0]  waveform_mode_field,
   input  wire logic [1:0]  compare_output_mode_field,
   input  wire tcc_evt_type evt,
   output logic             compare_output_pin
);
   typedef struct packed {
      logic oc;
      logic pin;
   } tcc_wg_state_type;

   tcc_wg_state_type st_r;
   tcc_wg_state_type st_nxt;
   logic             inv;

   assign inv = (compare_output_mode_field == TCC_COM_SET);

   // Output compare state per waveform mode
   always_comb
   begin
      st_nxt = st_r;
      if (evt.tick)
      begin
         case (waveform_mode_field)
            TCC_WGM_PHASE:
               if (evt.match && compare_output_mode_field[1])
                  st_nxt.oc = inv ^ evt.down;
            TCC_WGM_FAST:
               // Max wins so a compare at max gives a steady level
               if (evt.at_max && compare_output_mode_field[1])
                  st_nxt.oc = ~inv;
               else if (evt.match && compare_output_mode_field[1])
                  st_nxt.oc = inv;
            default:
               if (evt.match && compare_output_mode_field == TCC_COM_TOGGLE)
                  st_nxt.oc = ~st_r.oc;
               else if (evt.match && compare_output_mode_field[1])
                  st_nxt.oc = inv;
         endcase
      end
      st_nxt.pin = (compare_output_mode_field == TCC_COM_OFF) ? 1'b0 : st_nxt.oc;
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign compare_output_pin = st_r.pin;
endmodule

// [tcc_timer8.sv]
// 8-bit timer with one compare channel and an APB register slave
// Assumes a single pclk domain, APB3 master, prescaler taps from outside
//
// Notes on behaviour
// - Counter value and compare value are both eight bits wide.
// - Clock select zero gives no tick; the counter holds.
// - Tick comes from the system clock, prescaler taps or the external pin, chosen edge.
// - Bottom is 0x00 and maximum is 0xff.
// - Top is 0xff or the compare value, by mode.
// - Counter value is readable and writable with or without ticks.
// - Software counter write beats clear, increment and decrement.
// - Each tick clears, increments or decrements, by mode and direction.
// - Waveform mode field selects the counting sequence.
// - Overflow flag sets at the mode point and may request interrupts.
// - Comparator always checks counter against compare value.
// - Compare flag sets on the tick after equality is seen.
// - Compare request only with flag, its enable and global enable.
// - Compare flag clears on service or on writing one.
// - Waveform output follows match, waveform mode and output mode.
// - Waveform generator gets max and bottom indications.
// - Counter unit flags maximum at 0xff, top by mode and bottom at zero.
// - Each request is gated by its own bit in the mask register.
// - In PWM modes compare writes land in a buffer.
// - Buffer copies into the active compare only at top.
// - Normal and clear-on-match modes write the compare directly.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module tcc_timer8
   import tcc_pkg::*;
#(
   parameter int DW = 32
)
(
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic [11:0]   paddr,
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [DW-1:0] pwdata,
   output logic      [DW-1:0] prdata,
   output logic               pready,
   output logic               pslverr,
   input  wire logic [3:0]    prescale_tap,
   input  wire logic          external_count_pin,
   input  wire logic          global_int_enable,
   input  wire logic          ovf_int_ack,
   input  wire logic          cmp_int_ack,
   output logic               ovf_irq,
   output logic               cmp_irq,
   output logic               compare_output_pin
);
   // ************************************************
   // Parameter check
   // ************************************************
   if (DW != 32)
   begin : g_dw_chk
      $error("tcc_timer8: DW must be 32");
   end

   // ************************************************
   // State
   // ************************************************
   typedef struct packed {
      tcc_ctrl_type   timer_control_reg;
      logic [TCC_W-1:0] counter_value;
      logic [TCC_W-1:0] compare_value;
      logic [TCC_W-1:0] compare_buf;
      logic           down;
      logic           block;
      logic           overflow_flag;
      logic           compare_match_flag;
      logic [1:0]     timer_mask_reg;
      logic           ovf_irq;
      logic           cmp_irq;
      logic [31:0]    rdata;
      logic           ready;
      logic           slverr;
   } tcc_top_state_type;

   tcc_top_state_type st_r;
   tcc_top_state_type st_nxt;
   tcc_evt_type       evt;
   logic              tick;
   logic              setup;
   logic              wr;
   logic              wr_cnt;
   logic              wr_cmp;
   logic              wr_flag;
   logic              pwm;
   logic              at_max;
   logic              at_bottom;
   logic              at_top;
   logic              match;
   logic              ovf_set;
   logic              cmp_set;
   logic [1:0]        wgm;

   // One step up or down, wrapping at eight bits
   function automatic logic [TCC_W-1:0] cnt_step(input logic [TCC_W-1:0] v,
                                                 input logic dn);
      cnt_step = dn ? 8'(v - TCC_ONE) : 8'(v + TCC_ONE);
   endfunction

   // ************************************************
   // Tick source and waveform output
   // ************************************************
   tcc_tick_sel u_tick
   (
      .pclk               (pclk),
      .presetn            (presetn),
      .clock_select_field (st_r.timer_control_reg.clock_select_field),
      .prescale_tap       (prescale_tap),
      .external_count_pin (external_count_pin),
      .timer_tick         (tick)
   );

   tcc_wavegen u_wave
   (
      .pclk                      (pclk),
      .presetn                   (presetn),
      .waveform_mode_field       (wgm),
      .compare_output_mode_field (st_r.timer_control_reg.compare_output_mode_field),
      .evt                       (evt),
      .compare_output_pin        (compare_output_pin)
   );

   // ************************************************
   // Decode and indications
   // ************************************************
   assign wgm       = st_r.timer_control_reg.waveform_mode_field;
   assign setup     = psel & ~penable;
   assign wr        = psel & penable & st_r.ready & pwrite;
   assign wr_cnt    = wr && (paddr == TCC_OFF_COUNTER);
   assign wr_cmp    = wr && (paddr == TCC_OFF_COMPARE);
   assign wr_flag   = wr && (paddr == TCC_OFF_FLAG);
   assign pwm       = (wgm == TCC_WGM_PHASE) || (wgm == TCC_WGM_FAST);
   assign at_max    = (st_r.counter_value == TCC_MAX);
   assign at_bottom = (st_r.counter_value == TCC_BOTTOM);
   // Top is the compare value only when clearing on match
   assign at_top    = (wgm == TCC_WGM_CTC) ? match : at_max;
   assign match     = (st_r.counter_value == st_r.compare_value);
   assign cmp_set   = tick & match & ~st_r.block;
   assign ovf_set   = tick & ((wgm == TCC_WGM_PHASE) ? (at_bottom & st_r.down) : at_max);

   // Events for the waveform generator
   assign evt.tick      = tick;
   assign evt.match     = match & ~st_r.block;
   assign evt.at_max    = at_max;
   assign evt.at_bottom = at_bottom;
   assign evt.down      = st_r.down;

   // ************************************************
   // Next state
   // ************************************************
   always_comb
   begin
      st_nxt = st_r;

      // Counter sequence per mode
      if (tick)
      begin
         st_nxt.block = 1'b0;
         case (wgm)
            TCC_WGM_PHASE:
            begin
               if (!st_r.down && at_max)
                  st_nxt.down = 1'b1;
               else if (st_r.down && at_bottom)
                  st_nxt.down = 1'b0;
               st_nxt.counter_value = cnt_step(st_r.counter_value, st_nxt.down);
            end
            TCC_WGM_CTC:
            begin
               st_nxt.down = 1'b0;
               if (match)
                  st_nxt.counter_value = TCC_BOTTOM;
               else
                  st_nxt.counter_value = cnt_step(st_r.counter_value, 1'b0);
            end
            default:
            begin
               st_nxt.down          = 1'b0;
               st_nxt.counter_value = cnt_step(st_r.counter_value, 1'b0);
            end
         endcase
      end
      if (!pwm)
      begin
         st_nxt.down = 1'b0;
      end

      // Software write overrides counting and blocks the next match
      if (wr_cnt)
      begin
         st_nxt.counter_value = pwdata[7:0];
         st_nxt.block         = 1'b1;
      end

      // Compare buffering
      if (pwm && tick && at_top)
      begin
         st_nxt.compare_value = st_r.compare_buf;
      end
      if (wr_cmp)
      begin
         st_nxt.compare_buf = pwdata[7:0];
         if (!pwm)
            st_nxt.compare_value = pwdata[7:0];
      end

      // Other register writes
      if (wr && (paddr == TCC_OFF_CONTROL))
      begin
         st_nxt.timer_control_reg = tcc_ctrl_type'(pwdata[TCC_CTRL_W-1:0]);
      end
      if (wr && (paddr == TCC_OFF_MASK))
      begin
         st_nxt.timer_mask_reg = pwdata[1:0];
      end

      // Flags: clear by ack or one-write, a new event wins
      if (ovf_int_ack || (wr_flag && pwdata[TCC_OVF_BIT]))
         st_nxt.overflow_flag = 1'b0;
      if (cmp_int_ack || (wr_flag && pwdata[TCC_CMP_BIT]))
         st_nxt.compare_match_flag = 1'b0;
      if (ovf_set)
         st_nxt.overflow_flag = 1'b1;
      if (cmp_set)
         st_nxt.compare_match_flag = 1'b1;

      // Interrupt requests
      st_nxt.ovf_irq = st_nxt.overflow_flag & st_nxt.timer_mask_reg[TCC_OVF_BIT]
                       & global_int_enable;
      st_nxt.cmp_irq = st_nxt.compare_match_flag & st_nxt.timer_mask_reg[TCC_CMP_BIT]
                       & global_int_enable;

      // APB: data latched in setup, one access cycle
      st_nxt.ready = setup;
      if (setup)
      begin
         st_nxt.slverr = 1'b0;
         st_nxt.rdata  = 32'h0000_0000;
         if (paddr == TCC_OFF_CONTROL)
            st_nxt.rdata[TCC_CTRL_W-1:0] = st_r.timer_control_reg;
         else if (paddr == TCC_OFF_COUNTER)
            st_nxt.rdata[7:0] = st_r.counter_value;
         else if (paddr == TCC_OFF_COMPARE)
            st_nxt.rdata[7:0] = pwm ? st_r.compare_buf : st_r.compare_value;
         else if (paddr == TCC_OFF_FLAG)
            st_nxt.rdata[1:0] = {st_r.compare_match_flag, st_r.overflow_flag};
         else if (paddr == TCC_OFF_MASK)
            st_nxt.rdata[1:0] = st_r.timer_mask_reg;
         else
            st_nxt.slverr = 1'b1;
      end
   end

   // ************************************************
   // State register
   // ************************************************
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_r                   <= '0;
         st_r.timer_control_reg <= tcc_ctrl_type'(TCC_CTRL_RST);
         st_r.timer_mask_reg    <= TCC_MASK_RST;
      end
      else
         st_r <= st_nxt;
   end

   // Outputs straight from the state register
   assign prdata  = st_r.rdata;
   assign pready  = st_r.ready;
   assign pslverr = st_r.slverr;
   assign ovf_irq = st_r.ovf_irq;
   assign cmp_irq = st_r.cmp_irq;

   // ************************************************
   // Assertions
   // ************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_write_wins: assert property (wr_cnt |=> st_r.counter_value == $past(pwdata[7:0]))
      else $error("counter write lost");
   a_stop_holds: assert property ((st_r.timer_control_reg.clock_select_field == TCC_CS_STOP
      && $past(st_r.timer_control_reg.clock_select_field) == TCC_CS_STOP && !wr_cnt)
      |=> $stable(st_r.counter_value))
      else $error("stopped counter moved");
   a_ctc_clear: assert property ((tick && wgm == TCC_WGM_CTC && match && !wr_cnt)
      |=> st_r.counter_value == TCC_BOTTOM)
      else $error("no clear on match");
   a_normal_step: assert property ((tick && wgm == TCC_WGM_NORMAL && !wr_cnt)
      |=> st_r.counter_value == 8'($past(st_r.counter_value) + TCC_ONE))
      else $error("normal mode did not count up");
   a_cmp_flag_set: assert property (cmp_set |=> st_r.compare_match_flag)
      else $error("compare flag not set");
   a_cmp_irq_gate: assert property (st_r.cmp_irq |-> st_r.compare_match_flag
      && st_r.timer_mask_reg[TCC_CMP_BIT] && $past(global_int_enable))
      else $error("compare request without cause");
   a_ovf_irq_mask: assert property (st_r.ovf_irq |-> st_r.timer_mask_reg[TCC_OVF_BIT])
      else $error("overflow request while masked");
   a_cmp_flag_clr: assert property ((cmp_int_ack && !cmp_set)
      |=> !st_r.compare_match_flag)
      else $error("compare flag not cleared");
   a_buf_holds: assert property ((pwm && !(tick && at_top))
      |=> $stable(st_r.compare_value))
      else $error("active compare changed off top");
   a_buf_load: assert property ((pwm && tick && at_top)
      |=> st_r.compare_value == $past(st_r.compare_buf))
      else $error("buffer not loaded at top");
   a_direct_cmp: assert property ((wr_cmp && !pwm)
      |=> st_r.compare_value == $past(pwdata[7:0]))
      else $error("direct compare write lost");
   a_fast_ovf: assert property ((tick && wgm == TCC_WGM_FAST && at_max)
      |=> st_r.overflow_flag)
      else $error("overflow flag not set at max");
   a_apb_ready: assert property (setup |=> pready ##1 !pready)
      else $error("pready not a single cycle");

   // Phase correct overflow is raised when turning at bottom
   a_phase_ovf: assert property ((tick && wgm == TCC_WGM_PHASE && at_bottom && st_r.down)
      |=> st_r.overflow_flag)
      else $error("phase overflow flag not set");
   // A counter write hides the match of the next tick
   a_write_block: assert property (wr_cnt |=> st_r.block)
      else $error("counter write did not block match");
   // A stopped clock select never yields a tick
   a_stop_tick: assert property ((st_r.timer_control_reg.clock_select_field == TCC_CS_STOP
      && $past(st_r.timer_control_reg.clock_select_field) == TCC_CS_STOP) |-> !tick)
      else $error("tick while stopped");
   // Service of the overflow request clears its flag
   a_ovf_flag_clr: assert property ((ovf_int_ack && !ovf_set)
      |=> !st_r.overflow_flag)
      else $error("overflow flag not cleared");
   // Global enable low silences both requests
   a_irq_global: assert property (!global_int_enable
      |=> !st_r.ovf_irq && !st_r.cmp_irq)
      else $error("request while globally disabled");

   c_ctc_clear: cover property (tick && wgm == TCC_WGM_CTC && match);
   c_phase_turn: cover property (tick && wgm == TCC_WGM_PHASE && at_max ##1 st_r.down);
   c_cmp_irq: cover property (!cmp_irq ##1 cmp_irq);
   c_buf_load: cover property (pwm && tick && at_top && st_r.compare_buf != st_r.compare_value);
endmodule

// [tcc_timer8_tb.sv]
// Self-checking bench of the 8-bit timer compare unit
// Assumes the design files compile first; the bench plays APB master and tick sources
`timescale 1ns/100ps
module tcc_timer8_tb
   import tcc_pkg::*;
();
   // ************************************************
   // Signals, counters and the queue of expected reads
   // ************************************************
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, v;
   logic [3:0]  prescale_tap;
   logic        external_count_pin, global_int_enable, ovf_int_ack, cmp_int_ack;
   logic        ovf_irq, cmp_irq, compare_output_pin;
   logic [32:0] note;
   logic [32:0] exp_q[$];
   int          fails, samples_checked, cycles;
   integer      seed;

   tcc_timer8 #(.DW(32)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prescale_tap(prescale_tap), .external_count_pin(external_count_pin),
      .global_int_enable(global_int_enable), .ovf_int_ack(ovf_int_ack),
      .cmp_int_ack(cmp_int_ack), .ovf_irq(ovf_irq), .cmp_irq(cmp_irq),
      .compare_output_pin(compare_output_pin));

   // Free-running 200 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   // ************************************************
   // Tasks
   // ************************************************
   task automatic print_verdict();
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         fails = fails + 1;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50)
      begin
         n = n + 1;
         @(posedge pclk);
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, 1'b1, d);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic err);
      exp_q.push_back({err, d});
      apb(a, 1'b0, 32'h0);
   endtask

   function automatic logic [31:0] ctrl(input logic [1:0] com, input logic [1:0] wgm,
                                        input logic [2:0] cs);
      tcc_ctrl_type c;
      c = '{com, wgm, cs};
      return {25'h0, c};
   endfunction

   // Pulses the chosen tap, or gives the pin one full high-low period
   task automatic ticks(input logic [2:0] cs, input int n);
      repeat (n)
      begin
         @(posedge pclk);
         external_count_pin <= (cs >= TCC_CS_FALL);
         prescale_tap <= (cs >= TCC_CS_FALL) ? 4'h0 : 4'h1 << (cs - TCC_CS_TAP0);
         @(posedge pclk);
         prescale_tap <= 4'h0;
         repeat (8) @(posedge pclk);
         external_count_pin <= 1'b0;
         repeat (8) @(posedge pclk);
      end
   endtask

   task automatic pulse_ack(input logic cmp);
      @(posedge pclk);
      ovf_int_ack <= ~cmp;
      cmp_int_ack <= cmp;
      @(posedge pclk);
      ovf_int_ack <= 1'b0;
      cmp_int_ack <= 1'b0;
   endtask

   // ************************************************
   // Read monitor, timeout and main sequence
   // ************************************************
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         fails = fails + 1;
         print_verdict();
      end
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      begin
         note = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_dead_beef;
         chk("prdata", prdata, note[31:0]);
         chk("pslverr", 32'(pslverr), 32'(note[32]));
      end
   end

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, prescale_tap} = '0;
      {external_count_pin, global_int_enable, ovf_int_ack, cmp_int_ack} = '0;
      {fails, samples_checked, cycles} = '0;
      seed = 23992;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (int a = 0; a < 5; a++) rd(12'(a * 4), 32'h0, 1'b0);
      rd(12'h014, 32'h0, 1'b1);
      wr(12'h014, 32'hffff_ffff);
      v = $random(seed);
      wr(TCC_OFF_COUNTER, v);
      ticks(TCC_CS_TAP0, 2);
      rd(TCC_OFF_COUNTER, {24'h0, v[7:0]}, 1'b0);
      for (int cs = 2; cs < 8; cs++)
      begin
         wr(TCC_OFF_CONTROL, ctrl(TCC_COM_OFF, TCC_WGM_NORMAL, 3'(cs)));
         wr(TCC_OFF_COUNTER, 32'(8'h10 + cs));
         ticks(3'(cs), 3);
         rd(TCC_OFF_COUNTER, 32'(8'h13 + cs), 1'b0);
      end
      global_int_enable <= 1'b1;
      wr(TCC_OFF_MASK, 32'h3);
      wr(TCC_OFF_COMPARE, 32'h80);
      wr(TCC_OFF_CONTROL, ctrl(TCC_COM_TOGGLE, TCC_WGM_NORMAL, TCC_CS_TAP0));
      wr(TCC_OFF_COUNTER, 32'hfe);
      ticks(TCC_CS_TAP0, 2);
      rd(TCC_OFF_FLAG, 32'h1, 1'b0);
      chk("ovf_irq", 32'(ovf_irq), 32'h1);
      pulse_ack(1'b0);
      rd(TCC_OFF_FLAG, 32'h0, 1'b0);
      wr(TCC_OFF_COMPARE, 32'h10);
      wr(TCC_OFF_COUNTER, 32'h0e);
      ticks(TCC_CS_TAP0, 3);
      rd(TCC_OFF_FLAG, 32'h2, 1'b0);
      chk("cmp_irq", 32'(cmp_irq), 32'h1);
      chk("compare_output_pin", 32'(compare_output_pin), 32'h1);
      global_int_enable <= 1'b0;
      repeat (3) @(posedge pclk);
      chk("cmp_irq", 32'(cmp_irq), 32'h0);
      global_int_enable <= 1'b1;
      wr(TCC_OFF_MASK, 32'h1);
      @(posedge pclk);
      chk("cmp_irq", 32'(cmp_irq), 32'h0);
      pulse_ack(1'b1);
      rd(TCC_OFF_FLAG, 32'h0, 1'b0);
      wr(TCC_OFF_COUNTER, 32'h10);
      ticks(TCC_CS_TAP0, 1);
      rd(TCC_OFF_FLAG, 32'h0, 1'b0);
      wr(TCC_OFF_COUNTER, 32'h0f);
      ticks(TCC_CS_TAP0, 2);
      wr(TCC_OFF_FLAG, 32'h2);
      rd(TCC_OFF_FLAG, 32'h0, 1'b0);
      wr(TCC_OFF_CONTROL, ctrl(TCC_COM_OFF, TCC_WGM_CTC, TCC_CS_TAP0));
      wr(TCC_OFF_COMPARE, 32'h05);
      wr(TCC_OFF_COUNTER, 32'h0);
      ticks(TCC_CS_TAP0, 8);
      rd(TCC_OFF_COUNTER, 32'h2, 1'b0);
      rd(TCC_OFF_FLAG, 32'h2, 1'b0);
      wr(TCC_OFF_CONTROL, ctrl(TCC_COM_OFF, TCC_WGM_FAST, TCC_CS_TAP0));
      wr(TCC_OFF_COMPARE, 32'h33);
      rd(TCC_OFF_COMPARE, 32'h33, 1'b0);
      wr(TCC_OFF_FLAG, 32'h3);
      wr(TCC_OFF_COUNTER, 32'h31);
      ticks(TCC_CS_TAP0, 3);
      rd(TCC_OFF_FLAG, 32'h0, 1'b0);
      wr(TCC_OFF_COUNTER, 32'hfe);
      ticks(TCC_CS_TAP0, 2);
      rd(TCC_OFF_FLAG, 32'h1, 1'b0);
      wr(TCC_OFF_FLAG, 32'h3);
      wr(TCC_OFF_COUNTER, 32'h32);
      ticks(TCC_CS_TAP0, 2);
      rd(TCC_OFF_FLAG, 32'h2, 1'b0);
      wr(TCC_OFF_CONTROL, ctrl(TCC_COM_OFF, TCC_WGM_PHASE, TCC_CS_TAP0));
      wr(TCC_OFF_FLAG, 32'h3);
      wr(TCC_OFF_COUNTER, 32'hfe);
      ticks(TCC_CS_TAP0, 3);
      rd(TCC_OFF_COUNTER, 32'hfd, 1'b0);
      wr(TCC_OFF_COUNTER, 32'h02);
      ticks(TCC_CS_TAP0, 3);
      rd(TCC_OFF_COUNTER, 32'h01, 1'b0);
      rd(TCC_OFF_FLAG, 32'h1, 1'b0);
      repeat (5) @(posedge pclk);
      chk("pending reads", 32'(exp_q.size()), 32'h0);
      print_verdict();
   end
endmodule
